// [adcc_consts.vh]
// Function
// - control byte bits D1,D2 choose the output register for the next cycle
// - select 00 gives result B3-B10, select 01 gives result B11-B18
// - select 10 gives the status byte; select 11 gives invalid data
// - read-zero set makes the next conversion measure zero error with inputs shorted
// - sleep bit D5 enters sleep when end-of-conversion next rises; oscillator stops
// - serial interface keeps working while asleep
// - D6 zero integrates 546 counts, D6 one integrates 655 counts
// - start bit D7 launches exactly one conversion, then device idles
// - end-of-conversion is one whenever the conversion counter is 0000
// - start set with counter 0000 launches conversion and loads counter 0001
// - start bit clears automatically five oscillator cycles after launch
// - start is sampled only at count 0000, so an early start is held
// - commands are 8 bits, MSB first, shifted on rising clock, latched on select rise
// - output data shifts out on falling serial clock edges during the command
// - byte with D0 one goes to the user-output register, else control register
// - user-output register bits D4..D7 drive user outputs 0..3
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
`define ADCC_BIT_SEL_ZERO 0
`define ADCC_BIT_SEL_LO 1
`define ADCC_BIT_SEL_HI 2
`define ADCC_BIT_RZERO 4
`define ADCC_BIT_SLEEP 5
`define ADCC_BIT_LINE 6
`define ADCC_BIT_START 7
`define ADCC_SEL_LOW 2'h0
`define ADCC_SEL_HIGH 2'h1
`define ADCC_SEL_STAT 2'h2
`define ADCC_CNT_W 11
`define ADCC_CNT_IDLE 11'h000
`define ADCC_CNT_FIRST 11'h001
`define ADCC_CNT_LAST 11'h7FF
`define ADCC_CNT_START_CLR 11'h005
`define ADCC_INT_BEGIN 11'h010
`define ADCC_INT_60 11'h222
`define ADCC_INT_50 11'h28F
`define ADCC_BYTE_BITS 3'h7
`define ADCC_INVALID 8'hFF
`define ADCC_MSB 7
`define ADCC_START_AGE_LAST 3'h4
`endif

// [adcc_top.v]
`timescale 1ns/1ns
`include "adcc_consts.vh"
module adcc_top #(
	parameter RES_W = 19
) (
	input wire clock_i,
	input wire rstn_i,
	input wire ce_i,
	input wire sclk_i,
	input wire csn_i,
	input wire din_i,
	input wire osc_i,
	input wire [RES_W-1:0] result_i,
	input wire result_valid_i,
	input wire polarity_neg_i,
	input wire collision_i,
	output reg dout_o,
	output reg eoc_o,
	output reg integrating_o,
	output reg sleep_o,
	output reg read_zero_o,
	output reg [3:0] user_out_o,
	output reg [`ADCC_CNT_W-1:0] conv_count_o
);
	// ==========================================
	// input synchronisers
	reg [1:0] sclk_s, csn_s, din_s, osc_s;
	reg sclk_d, csn_d, osc_d;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sclk_s <= 2'h0;
			csn_s <= 2'h3;
			din_s <= 2'h0;
			osc_s <= 2'h0;
			sclk_d <= 1'b0;
			csn_d <= 1'b1;
			osc_d <= 1'b0;
		end else if (ce_i) begin
			sclk_s <= {sclk_s[0], sclk_i};
			csn_s <= {csn_s[0], csn_i};
			din_s <= {din_s[0], din_i};
			osc_s <= {osc_s[0], osc_i};
			sclk_d <= sclk_s[1];
			csn_d <= csn_s[1];
			osc_d <= osc_s[1];
		end
	end
	wire sclk_rise = sclk_s[1] & ~sclk_d;
	wire sclk_fall = ~sclk_s[1] & sclk_d;
	wire cs_rise = csn_s[1] & ~csn_d;
	wire cs_fall = ~csn_s[1] & csn_d;
	// oscillator stops in sleep; only conversion logic sees its ticks
	wire osc_tick = osc_s[1] & ~osc_d & ~sleep_o;

	// ==========================================
	// serial command path
	reg [7:0] shift_in;
	reg [7:0] shift_out;
	reg [1:0] reg_select;
	reg line_50hz;
	reg start_req;
	reg sleep_req;
	reg [RES_W-1:0] result;
	reg collision;
	wire [7:0] cmd_byte = {shift_in[6:0], din_s[1]};

	function [7:0] adcc_out_byte;
		input [1:0] sel;
		input [RES_W-1:0] res;
		input [4:0] flags;
		begin
			case (sel)
				`ADCC_SEL_LOW: adcc_out_byte = res[10:3];
				`ADCC_SEL_HIGH: adcc_out_byte = res[18:11];
				`ADCC_SEL_STAT: adcc_out_byte = {flags, res[2:0]};
				default: adcc_out_byte = `ADCC_INVALID;
			endcase
		end
	endfunction

	wire [4:0] status_flags = {collision, eoc_o, integrating_o, sleep_o, polarity_neg_i};
	wire [7:0] sel_byte = adcc_out_byte(reg_select, result, status_flags);
	reg start_set;
	reg stat_read;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			dout_o <= 1'b0;
			reg_select <= `ADCC_SEL_LOW;
			line_50hz <= 1'b0;
			sleep_req <= 1'b0;
			read_zero_o <= 1'b0;
			user_out_o <= 4'h0;
			start_set <= 1'b0;
			stat_read <= 1'b0;
		end else if (ce_i) begin
			start_set <= 1'b0;
			stat_read <= 1'b0;
			// interface runs from clock_i, so it stays alive in sleep
			if (cs_fall) begin
				shift_out <= sel_byte;
				dout_o <= sel_byte[`ADCC_MSB];
				stat_read <= (reg_select == `ADCC_SEL_STAT);
			end else if (!csn_s[1] && sclk_fall) begin
				shift_out <= {shift_out[6:0], 1'b0};
				dout_o <= shift_out[`ADCC_MSB - 1];
			end
			if (!csn_s[1] && sclk_rise)
				shift_in <= cmd_byte;
			if (cs_rise) begin
				if (shift_in[`ADCC_BIT_SEL_ZERO]) begin
					user_out_o <= shift_in[7:4];
				end else begin
					reg_select <= {shift_in[`ADCC_BIT_SEL_LO], shift_in[`ADCC_BIT_SEL_HI]};
					read_zero_o <= shift_in[`ADCC_BIT_RZERO];
					sleep_req <= shift_in[`ADCC_BIT_SLEEP];
					line_50hz <= shift_in[`ADCC_BIT_LINE];
					start_set <= shift_in[`ADCC_BIT_START];
				end
			end
		end
	end

	// ==========================================
	// start request handling
	reg [2:0] start_age;
	reg launched;
	wire at_idle = (conv_count_o == `ADCC_CNT_IDLE);
	// a start landing in the launch cycle itself waits for the next idle count
	wire launch_now = osc_tick & at_idle & start_req & ~start_set;
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			start_req <= 1'b0;
			start_age <= 3'h0;
			launched <= 1'b0;
		end else if (ce_i) begin
			if (start_set)
				start_req <= 1'b1; // held until cleared five oscillator ticks after launch
			if (launch_now) begin
				launched <= 1'b1;
				start_age <= 3'h0;
			end else if (osc_tick && launched) begin
				start_age <= start_age + 3'h1;
				// a start written in the same cycle as the clear survives it
				if (start_age == `ADCC_START_AGE_LAST) begin
					start_req <= start_set;
					launched <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// conversion counter
	function [`ADCC_CNT_W-1:0] adcc_int_end;
		input line50;
		begin
			if (line50)
				adcc_int_end = `ADCC_INT_BEGIN + `ADCC_INT_50;
			else
				adcc_int_end = `ADCC_INT_BEGIN + `ADCC_INT_60;
		end
	endfunction

	wire [`ADCC_CNT_W-1:0] int_end = adcc_int_end(line_50hz);
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			conv_count_o <= `ADCC_CNT_IDLE;
			eoc_o <= 1'b1;
			integrating_o <= 1'b0;
		end else if (ce_i && osc_tick) begin
			if (launch_now) begin
				conv_count_o <= `ADCC_CNT_FIRST;
				eoc_o <= 1'b0;
			end else if (conv_count_o == `ADCC_CNT_LAST) begin
				conv_count_o <= `ADCC_CNT_IDLE; // single shot
				eoc_o <= 1'b1;
			end else if (!at_idle) begin
				conv_count_o <= conv_count_o + `ADCC_CNT_FIRST;
			end
			// integrate phase opens at a fixed count and closes at a count chosen by line_50hz
			if (conv_count_o == `ADCC_INT_BEGIN)
				integrating_o <= 1'b1;
			if (conv_count_o == int_end)
				integrating_o <= 1'b0;
		end
	end

	// ==========================================
	// sleep control
	wire sleep_enter = osc_tick & (conv_count_o == `ADCC_CNT_LAST) & sleep_req;
	// any control byte without the sleep bit wakes the device
	wire sleep_wake = cs_rise & ~shift_in[`ADCC_BIT_SEL_ZERO] & ~shift_in[`ADCC_BIT_SLEEP];
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sleep_o <= 1'b0;
		end else if (ce_i) begin
			// entering wins a tie, matching the eoc edge that triggers it
			if (sleep_enter)
				sleep_o <= 1'b1;
			else if (sleep_wake)
				sleep_o <= 1'b0;
		end
	end

	// ==========================================
	// result capture and collision flag
	always @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			result <= {RES_W{1'b0}};
			collision <= 1'b0;
		end else if (ce_i) begin
			if (result_valid_i)
				result <= result_i;
			// a result landing inside a frame beats the collision_i load of a status read
			if (result_valid_i && !csn_s[1])
				collision <= 1'b1;
			else if (stat_read)
				collision <= collision_i;
		end
	end
endmodule // adcc_top

// [adcc_monitor.sv]
`timescale 1ns/1ns
// ==========
// port checks
module adcc_monitor (
	input wire clock_i,
	input wire rstn_i,
	input wire csn_i,
	input wire eoc_o,
	input wire integrating_o,
	input wire sleep_o,
	input wire read_zero_o,
	input wire [3:0] user_out_o,
	input wire [10:0] conv_count_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_eoc_at_zero: assert property (eoc_o == (conv_count_o == 11'h000))
		else $error("eoc not tied to zero count");
	a_count_step: assert property ($changed(conv_count_o) |->
		conv_count_o - $past(conv_count_o) == 11'h001) else $error("count jumped");
	a_eoc_fall_one: assert property ($fell(eoc_o) |-> conv_count_o == 11'h001)
		else $error("launch not at count one");
	a_integ_window: assert property (integrating_o |->
		conv_count_o >= 11'h011 && conv_count_o <= 11'h29F) else $error("integrating off window");
	a_sleep_at_eoc: assert property ($rose(sleep_o) |-> eoc_o)
		else $error("sleep before eoc");
	a_sleep_frozen: assert property (sleep_o && $past(sleep_o) |-> $stable(conv_count_o))
		else $error("count moved asleep");
	a_user_latch: assert property ($changed(user_out_o) |-> csn_i)
		else $error("user outputs moved in frame");
	a_zero_latch: assert property ($changed(read_zero_o) |-> csn_i)
		else $error("read zero moved in frame");
endmodule // adcc_monitor
bind adcc_top adcc_monitor mon (.clock_i, .rstn_i, .csn_i, .eoc_o, .integrating_o, .sleep_o,
	.read_zero_o, .user_out_o, .conv_count_o);

// [adcc_host.sv]
`timescale 1ns/1ns
// ==========
// host end of the serial link
module adcc_host (
	input wire clock_i,
	input wire dout_i,
	output reg sclk_o = 1'b0,
	output reg csn_o = 1'b1,
	output reg din_o = 1'b0
);
	reg [7:0] rd;
	event done;
	// sclk rests low outside frames; released din is inverted as it has no pull
	task xfer(input [7:0] c);
		integer i;
		@(posedge clock_i);
		csn_o <= 1'b0;
		din_o <= c[7];
		for (i = 7; i >= 0; i = i - 1) begin
			repeat (5) @(posedge clock_i);
			rd[i] = dout_i;
			sclk_o <= 1'b1;
			repeat (5) @(posedge clock_i);
			sclk_o <= 1'b0;
			if (i > 0) din_o <= c[i-1];
		end
		repeat (5) @(posedge clock_i);
		csn_o <= 1'b1;
		din_o <= ~din_o;
		repeat (10) @(posedge clock_i);
		->done;
	endtask
endmodule // adcc_host

// [tb.sv]
`timescale 1ns/1ns
// ==========
// stimulus and checks
module tb;
	reg clock_i = 0, rstn_i = 0, rv = 0, neg = 0, osc = 0;
	reg [18:0] res = 0;
	reg [10:0] lc = 0;
	reg [1:0] oc = 0;
	wire sclk, csn, din, dout, eoc, integ, slp, rz;
	wire [3:0] uo;
	wire [10:0] cnt;
	integer fails = 0, num_checks = 0, ni = 0, k, seed = 32'h8083D4FA;
	logic [8:0] q[$];
	logic [8:0] x;
	always #4 clock_i = ~clock_i;
	// slow oscillator so every count lasts several samples
	always @(posedge clock_i) begin
		oc <= oc + 2'h1;
		osc <= oc[1];
		lc <= cnt;
		if (cnt === 11'h001) ni <= 0;
		else if (integ === 1'b1 && cnt !== lc) ni <= ni + 1;
	end
	adcc_top dut (.clock_i, .rstn_i, .ce_i(1'b1), .sclk_i(sclk), .csn_i(csn), .din_i(din),
		.osc_i(osc), .result_i(res), .result_valid_i(rv), .polarity_neg_i(neg),
		.collision_i(1'b0), .dout_o(dout), .eoc_o(eoc), .integrating_o(integ), .sleep_o(slp),
		.read_zero_o(rz), .user_out_o(uo), .conv_count_o(cnt));
	adcc_host host (.clock_i, .dout_i(dout), .sclk_o(sclk), .csn_o(csn), .din_o(din));
	task chk(input logic [15:0] g, e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	always @(host.done) begin
		x = q.pop_front();
		if (x[8]) chk(16'(host.rd), 16'(x[7:0]));
	end
	task tx(input [7:0] c, e, input ck);
		q.push_back({ck, e});
		host.xfer(c);
	endtask
	task wt(input v);
		for (int i = 0; i < 10000 && eoc !== v; i++) @(posedge clock_i);
		chk(16'(eoc), 16'(v));
	endtask
	task finish_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial #400000 begin
		fails++;
		finish_test;
	end
	initial begin
		repeat (16) @(posedge clock_i);
		rstn_i <= 1;
		res <= 19'($random(seed));
		neg <= 1'($random(seed));
		rv <= 1;
		@(posedge clock_i);
		rv <= 0;
		tx(8'h00, 8'h00, 0);
		tx(8'h04, res[10:3], 1);
		tx(8'h02, res[18:11], 1);
		tx(8'h06, {4'h4, neg, res[2:0]}, 1);
		tx(8'hA1, 8'hFF, 1);
		chk(16'(uo), 16'h000A);
		// one measurement, then two zero readings, the second one also setting the sleep bit
		for (k = 0; k < 3; k++) begin
			tx(k == 0 ? 8'h82 : k == 1 ? 8'hD2 : 8'hF2, k ? res[18:11] : 8'hFF, 1);
			chk(16'(rz), 16'(k != 0));
			wt(0);
			wt(1);
			chk(16'(ni), k ? 16'h028F : 16'h0222);
			repeat (40) @(posedge clock_i);
			chk(16'(cnt), 16'h0000);
			chk(16'(slp), 16'(k == 2));
			tx(8'h04, {2'h1, 1'h0, 1'(k == 2), neg, res[2:0]}, 1);
			chk(16'(slp), 16'h0000);
		end
		finish_test;
	end
endmodule // tb
